/* port_data_latch_bank.sv */
// port data latches, direction bits and read-back for the port bank
`timescale 1ns/1ps
`default_nettype none
// Operation
// - written bit latched and driven when output
// - input-mode read returns pin level
// - output-mode read returns latch value
// - bit and byte accesses both supported
// - reset clears every output latch
// - port 12 oscillator bits are read-only
// - oscillator bits undefined after reset
// - clock-input pins read as zero
// - direction bit zero output, resets one
// - clock mode select resets to zero
module port_data_latch_bank
	import port_latch_pkg::*;
#(
	parameter int PORTS = NUM_PORTS
) (
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire bus_req_t             busReq,
	input  wire logic [PORTS*8-1:0]   pinIn,
	output var  logic [7:0]           rdata,
	output var  logic                 rvalid,
	output var  pin_drive_t           pinOut
);

	// the address and mask tables are fixed at ten ports
	if (PORTS != NUM_PORTS) begin : g_bad_ports
		$error("port count must match the register map");
	end

	// ----------------------------------------------------------------
	// address tables
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDRS [PORTS] = '{PORT1_ADDR, PORT2_ADDR,
		PORT3_ADDR, PORT4_ADDR, PORT8_ADDR, PORT10_ADDR, PORT11_ADDR,
		PORT12_ADDR, PORT14_ADDR, PORT15_ADDR};
	localparam logic [7:0] MASKS [PORTS] = '{MASK_P1, MASK_P2, MASK_P3,
		MASK_P4, MASK_P8, MASK_P10, MASK_P11, MASK_P12, MASK_P14,
		MASK_P15};

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] latch_q [PORTS];
	logic [7:0] latch_d [PORTS];
	logic [7:0] dir_q   [PORTS];
	logic [7:0] dir_d   [PORTS];
	logic [7:0] clkMode_q;
	logic [7:0] clkMode_d;
	logic [7:0] rdata_d;
	logic       rvalid_d;
	pin_drive_t pinOut_d;

	function automatic logic [7:0] merge(input logic [7:0] old,
		input bus_req_t r, input logic [7:0] mask);
		logic [7:0] v;
		v = old;
		if (r.bitOp)
			v[r.bitSel] = r.wdata[0];
		else
			v = r.wdata;
		return v & mask;
	endfunction : merge

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [7:0] view;
		logic [7:0] wmask;
		view      = 8'h00;
		wmask     = 8'h00;
		clkMode_d = clkMode_q;
		rdata_d   = 8'h00;
		rvalid_d  = busReq.rd;
		pinOut_d  = '0;
		for (int i = 0; i < PORTS; i++) begin
			latch_d[i] = latch_q[i];
			dir_d[i]   = dir_q[i];
			wmask = (i == PORT12_IDX) ? (MASKS[i] & ~OSC_BITS) : MASKS[i];
			if (busReq.wr && busReq.addr == ADDRS[i])
				latch_d[i] = merge(latch_q[i], busReq, wmask);
			if (busReq.wr && busReq.addr == ADDRS[i] + PM_BASE - 16'hFF00)
				dir_d[i] = merge(dir_q[i], busReq, wmask) | ~wmask;
			view = (dir_q[i] & pinIn[i*8 +: 8])
				| (~dir_q[i] & latch_q[i]);
			if (i == PORT12_IDX) begin
				view = (view & ~OSC_BITS) | (pinIn[i*8 +: 8] & OSC_BITS);
				view = view & ~clkMode_q;
			end
			if (busReq.rd && busReq.addr == ADDRS[i])
				rdata_d = view & MASKS[i];
			if (busReq.rd && busReq.addr == ADDRS[i] + PM_BASE - 16'hFF00)
				rdata_d = dir_q[i];
			pinOut_d.level[i*8 +: 8]  = latch_q[i] & wmask;
			pinOut_d.enable[i*8 +: 8] = ~dir_q[i] & wmask;
		end
		if (busReq.wr && busReq.addr == CLKMODE_ADDR)
			clkMode_d = merge(clkMode_q, busReq, OSC_BITS);
		if (busReq.rd && busReq.addr == CLKMODE_ADDR)
			rdata_d = clkMode_q;
		// bit reads return the chosen bit in bit 0
		if (busReq.bitOp)
			rdata_d = {7'h00, rdata_d[busReq.bitSel]};
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < PORTS; i++) begin
				latch_q[i] <= DATA_RESET;
				dir_q[i]   <= DIR_RESET;
			end
			clkMode_q <= CLKMODE_RESET;
			rdata     <= 8'h00;
			rvalid    <= 1'b0;
			pinOut    <= '0;
		end else begin
			for (int i = 0; i < PORTS; i++) begin
				latch_q[i] <= latch_d[i];
				dir_q[i]   <= dir_d[i];
			end
			clkMode_q <= clkMode_d;
			rdata     <= rdata_d;
			rvalid    <= rvalid_d;
			pinOut    <= pinOut_d;
		end
	end

endmodule : port_data_latch_bank
`default_nettype wire

/* port_latch_pkg.sv */
// constants and carrier types for the port data latch bank
package port_latch_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int          NUM_PORTS   = 10;
	localparam logic [15:0] PORT1_ADDR  = 16'hFF01;
	localparam logic [15:0] PORT2_ADDR  = 16'hFF02;
	localparam logic [15:0] PORT3_ADDR  = 16'hFF03;
	localparam logic [15:0] PORT4_ADDR  = 16'hFF04;
	localparam logic [15:0] PORT8_ADDR  = 16'hFF08;
	localparam logic [15:0] PORT10_ADDR = 16'hFF0A;
	localparam logic [15:0] PORT11_ADDR = 16'hFF0B;
	localparam logic [15:0] PORT12_ADDR = 16'hFF0C;
	localparam logic [15:0] PORT14_ADDR = 16'hFF0E;
	localparam logic [15:0] PORT15_ADDR = 16'hFF0F;
	localparam logic [15:0] PM_BASE     = 16'hFF20;
	localparam logic [15:0] CLKMODE_ADDR = 16'hFF40;

	// ----------------------------------------------------------------
	// reset values and implemented pin masks
	// ----------------------------------------------------------------
	localparam logic [7:0] DATA_RESET    = 8'h00;
	localparam logic [7:0] DIR_RESET     = 8'hFF;
	localparam logic [7:0] CLKMODE_RESET = 8'h00;
	localparam logic [7:0] MASK_P1  = 8'h0E;
	localparam logic [7:0] MASK_P2  = 8'h3F;
	localparam logic [7:0] MASK_P3  = 8'h1E;
	localparam logic [7:0] MASK_P4  = 8'h03;
	localparam logic [7:0] MASK_P8  = 8'h01;
	localparam logic [7:0] MASK_P10 = 8'h03;
	localparam logic [7:0] MASK_P11 = 8'h0E;
	localparam logic [7:0] MASK_P12 = 8'h1F;
	localparam logic [7:0] MASK_P14 = 8'h0F;
	localparam logic [7:0] MASK_P15 = 8'h0F;
	// port 12 bits 1..4 are read-only oscillator-shared pins
	localparam logic [7:0] OSC_BITS = 8'h1E;
	localparam int         PORT12_IDX = 7;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        bitOp;
		logic [2:0]  bitSel;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bus_req_t;

	typedef struct packed {
		logic [NUM_PORTS*8-1:0] level;
		logic [NUM_PORTS*8-1:0] enable;
	} pin_drive_t;

endpackage : port_latch_pkg

/* port_data_latch_bank_asserts.sv */
// assertions on the port bank's read port and pin drivers
`timescale 1ns/1ps
`default_nettype none
module port_data_latch_bank_asserts
	import port_latch_pkg::*;
#(parameter int PORTS = NUM_PORTS) (
	input wire logic               mclk,
	input wire logic               srst,
	input wire bus_req_t           busReq,
	input wire logic [PORTS*8-1:0] pinIn,
	input wire logic [7:0]         rdata,
	input wire logic               rvalid,
	input wire pin_drive_t         pinOut
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_p3rd;
		busReq.rd && !busReq.bitOp && busReq.addr == PORT3_ADDR;
	endsequence
	chk_read_answer: assert property (busReq.rd |=> rvalid)
		else $error("read without rvalid");
	chk_idle_quiet: assert property (!busReq.rd |=> !rvalid && !rdata)
		else $error("read data outside a read");
	chk_unmapped_zero: assert property (busReq.rd &&
		busReq.addr == 16'hFF10 |=> rdata == 8'h00) else $error("bad unmapped");
	chk_input_pin: assert property (s_p3rd ##1 !pinOut.enable[23:16]
		|-> rdata == ($past(pinIn[23:16]) & MASK_P3)) else $error("bad pin read");
	chk_output_latch: assert property (s_p3rd ##1
		pinOut.enable[23:16] == MASK_P3 |-> rdata == pinOut.level[23:16])
		else $error("bad latch read");
	chk_write_drive: assert property (busReq.wr && !busReq.bitOp &&
		busReq.addr == PORT3_ADDR |-> ##2
		pinOut.level[23:16] == ($past(busReq.wdata, 2) & MASK_P3))
		else $error("latch not driven");
	chk_dir_enable: assert property (busReq.wr && !busReq.bitOp &&
		busReq.addr == 16'hFF23 |-> ##2
		pinOut.enable[23:16] == (~$past(busReq.wdata, 2) & MASK_P3))
		else $error("bad enable");
	chk_reset_clear: assert property ($fell(srst) |-> pinOut == '0)
		else $error("pins not cleared");
	chk_osc_undriven: assert property (!pinOut.enable[60:57])
		else $error("osc pin driven");
endmodule : port_data_latch_bank_asserts
bind port_data_latch_bank port_data_latch_bank_asserts #(.PORTS(PORTS)) i_chk (
	.mclk(mclk), .srst(srst), .busReq(busReq), .pinIn(pinIn),
	.rdata(rdata), .rvalid(rvalid), .pinOut(pinOut));
`default_nettype wire

/* tb_port_data_latch_bank.sv */
// self-checking bench for the port data latch bank
`timescale 1ns/1ps
`default_nettype none
module tb_port_data_latch_bank;
	import port_latch_pkg::*;
	logic       mclk, srst, rvalid;
	bus_req_t   busReq;
	logic [79:0] pinIn;
	logic [7:0] rdata, q;
	pin_drive_t pinOut;
	int         errTotal, checksDone;
	port_data_latch_bank i_dut (.mclk(mclk), .srst(srst), .busReq(busReq),
		.pinIn(pinIn), .rdata(rdata), .rvalid(rvalid), .pinOut(pinOut));
	always #25 mclk = ~mclk;
	// k is {rd, wr, bitOp}; request held across one rising edge
	task automatic acc(input logic [2:0] k, s, input logic [15:0] a,
		input logic [7:0] d);
		@(negedge mclk) busReq = '{k[2], k[1], k[0], s, a, d};
		@(negedge mclk) busReq = '0;
		q = rdata;
	endtask : acc
	task automatic chk(input string n, input logic [7:0] s, e);
		checksDone++;
		if (s !== e) begin
			errTotal++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, errTotal);
		if (errTotal == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	task automatic t_port3;
		acc(4, 0, PORT3_ADDR, 0); chk("p3 in", q, 8'h04);
		acc(2, 0, 16'hFF23, 0);
		acc(4, 0, PORT3_ADDR, 0); chk("p3 reset", q, 8'h00);
		acc(2, 0, PORT3_ADDR, 8'hFF);
		acc(4, 0, PORT3_ADDR, 0); chk("p3 out", q, 8'h1E);
		chk("p3 level", pinOut.level[23:16], 8'h1E);
		chk("p3 enable", pinOut.enable[23:16], 8'h1E);
		$display("port3 test done");
	endtask : t_port3
	task automatic t_bit;
		acc(2, 0, 16'hFF2E, 0);
		acc(3, 2, PORT14_ADDR, 1);
		acc(4, 0, PORT14_ADDR, 0); chk("p14 byte", q, 8'h04);
		acc(5, 2, PORT14_ADDR, 0); chk("p14 bit", q, 8'h01);
		$display("bit test done");
	endtask : t_bit
	task automatic t_osc;
		acc(2, 0, 16'hFF2C, 0);
		acc(2, 0, PORT12_ADDR, 8'hFF);
		acc(4, 0, PORT12_ADDR, 0); chk("p12", q, 8'h05);
		acc(2, 0, CLKMODE_ADDR, 8'h1E);
		acc(4, 0, PORT12_ADDR, 0); chk("p12 clk", q, 8'h01);
		acc(4, 0, 16'hFF10, 0); chk("unmapped", q, 8'h00);
		$display("osc test done");
	endtask : t_osc
	initial begin
		mclk = 0; srst = 1; busReq = '0; pinIn = {10{8'hA5}};
		errTotal = 0; checksDone = 0;
		repeat (3) @(negedge mclk);
		srst = 0;
		t_port3;
		t_bit;
		t_osc;
		tally_and_finish;
	end
	// about 33 cycles of traffic; twelve times that is a hang
	initial begin
		#20000;
		errTotal++;
		tally_and_finish;
	end
endmodule : tb_port_data_latch_bank
`default_nettype wire
